// ===== rtl/cas_alarm.sv
/*
 Per-alarm state logic: hold policy, start-up suppression, onset delay,
 acknowledge, masking, status and interrupt, behind a Wishbone slave.
 Assumes trigger and normal-condition inputs come from another domain,
 and a single 10 MHz clock with synchronous active-low reset.
*/
`timescale 1ns/1ps
// Summary of operation
// - Policy 0: alarm clears as soon as trigger drops, no acknowledge.
// - Policy 1: alarm holds until cleared and acknowledged; acknowledge accepted anytime.
// - Policy 2: acknowledge only accepted after trigger cleared; earlier ones ignored.
// - Policy 3: non-holding alarm used as internal trigger, never annunciated.
// - Suppression 1 blocks alarm after start-up until value first normal.
// - An unacknowledged held alarm is retained, not suppressed; a reference write that re-arms blocking clears it.
// - Writing the reference while suppression is on re-arms blocking.
// - Onset delay 0.0 to 9999.9 s between trigger and activation.
// - Trigger dropping before delay expiry resets the timer, no activation.
// - Zero delay activates immediately with the trigger.
// - Alarm output is 1 whenever status is not off.
// - Acknowledge written as 1 is taken, then returns to 0 itself.
// - Mask set forces the alarm off and status off.
// - Active alarm goes off on masking; status recomputed on unmask.
// - Trigger during mask leaves alarm off until unmask, then evaluated.
// - Status codes: 0 off, 1 active acked, 2 inactive unacked, 3 active unacked.
module cas_alarm
   import cas_pkg::*;
#(
   parameter int TICK_DIV = CAS_TICK_CYC,
   parameter int DELAY_W = CAS_DELAY_W
) (
   // Clocking
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Monitored conditions
   input wire logic trigger_in,
   input wire logic value_normal_in,
   // Alarm results
   output logic alarm_out,
   output logic [1:0] alarm_state,
   output logic annunciate,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////
   // Refused at elaboration, before any logic is built
   if (DELAY_W < CAS_DELAY_W || DELAY_W > 31) begin : g_bad_delay_w
      $error("cas_alarm: DELAY_W cannot hold the delay range");
   end
   if (TICK_DIV < 1) begin : g_bad_tick_div
      $error("cas_alarm: TICK_DIV must be at least one");
   end

   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   logic [1:0] pol_q;
   logic sup_en_q;
   logic mask_q;
   logic ack_pend_q;
   logic [DELAY_W-1:0] delay_q;
   logic [31:0] ref_q;
   logic [CAS_IRQ_W-1:0] irq_stat_q;
   logic [CAS_IRQ_W-1:0] irq_mask_q;
   logic blocked_q;
   logic lat_q;
   logic acked_q;
   logic [DELAY_W-1:0] cnt_q;
   logic trig_s;
   logic normal_s;
   logic tick;
   logic req;
   logic wr;
   logic wr_ctrl;
   logic ref_wr;
   logic rearm;
   logic blk;
   logic arm_trig;
   logic act;
   logic latching;
   logic ack_ok;
   logic clr;
   logic [1:0] st;
   logic out_d;
   logic [CAS_IRQ_W-1:0] ev;
   logic [31:0] rd;
   logic [31:0] ctrl_rd;
   logic [31:0] wdat;

   ////////////////////////////////////////////////////////////////////
   cas_sync3 u_sync_trig (
      .mclk(mclk),
      .nrst(nrst),
      .ce(ce),
      .d(trigger_in),
      .q(trig_s)
   );

   cas_sync3 u_sync_norm (
      .mclk(mclk),
      .nrst(nrst),
      .ce(ce),
      .d(value_normal_in),
      .q(normal_s)
   );

   cas_tick #(
      .DIV(TICK_DIV)
   ) u_tick (
      .mclk(mclk),
      .nrst(nrst),
      .ce(ce),
      .tick(tick)
   );

   ////////////////////////////////////////////////////////////////////
   // Writes land on the edge where the master sees ack
   assign req = wb_cyc_i & wb_stb_i;
   assign wr = req & wb_we_i & wb_ack_o;
   assign wr_ctrl = wr && wb_adr_i == CAS_OFS_CTRL;
   assign ref_wr = wr && wb_adr_i == CAS_OFS_REF;
   assign ctrl_rd = {27'h0, ack_pend_q, mask_q, sup_en_q, pol_q};
   assign wdat = merge(ctrl_rd, wb_dat_i, wb_sel_i);

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         wb_ack_o <= 1'b0;
      end else if (ce) begin
         wb_ack_o <= req & ~wb_ack_o;
      end
   end

   always_comb begin
      rd = 32'h0;
      if (wb_adr_i == CAS_OFS_CTRL) begin
         rd = ctrl_rd;
      end else if (wb_adr_i == CAS_OFS_DELAY) begin
         rd = 32'(delay_q);
      end else if (wb_adr_i == CAS_OFS_REF) begin
         rd = ref_q;
      end else if (wb_adr_i == CAS_OFS_STATUS) begin
         rd[CAS_ST_STATE_LSB +: 2] = alarm_state;
         rd[CAS_ST_OUT_BIT] = alarm_out;
         rd[CAS_ST_TRIG_BIT] = trig_s;
         rd[CAS_ST_BLK_BIT] = blk;
         rd[CAS_ST_TIMING_BIT] = arm_trig & ~act;
      end else if (wb_adr_i == CAS_OFS_IRQ_STAT) begin
         rd = 32'(irq_stat_q);
      end else if (wb_adr_i == CAS_OFS_IRQ_MASK) begin
         rd = 32'(irq_mask_q);
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         wb_dat_o <= 32'h0;
      end else if (ce && req && !wb_ack_o) begin
         wb_dat_o <= rd;
      end
   end

   // Configuration registers
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         pol_q <= CAS_RST_POL;
         sup_en_q <= CAS_RST_SUP;
         mask_q <= CAS_RST_MASK;
         delay_q <= CAS_RST_DELAY[DELAY_W-1:0];
         ref_q <= CAS_RST_REF;
         irq_mask_q <= CAS_RST_IRQ_MASK;
      end else if (ce && wr) begin
         if (wb_adr_i == CAS_OFS_CTRL) begin
            pol_q <= wdat[CAS_CTRL_POL_LSB +: 2];
            sup_en_q <= wdat[CAS_CTRL_SUP_BIT];
            mask_q <= wdat[CAS_CTRL_MASK_BIT];
         end else if (wb_adr_i == CAS_OFS_DELAY) begin
            // Out of range values saturate rather than wrap
            if (merge(32'(delay_q), wb_dat_i, wb_sel_i) > 32'(CAS_DELAY_MAX_TENTHS)) begin
               delay_q <= DELAY_W'(CAS_DELAY_MAX_TENTHS);
            end else begin
               delay_q <= DELAY_W'(merge(32'(delay_q), wb_dat_i, wb_sel_i));
            end
         end else if (wb_adr_i == CAS_OFS_REF) begin
            ref_q <= merge(ref_q, wb_dat_i, wb_sel_i);
         end else if (wb_adr_i == CAS_OFS_IRQ_MASK) begin
            irq_mask_q <= CAS_IRQ_W'(merge(32'(irq_mask_q), wb_dat_i, wb_sel_i));
         end
      end
   end

   // Acknowledge lives one cycle, taken or dropped, then reads zero
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ack_pend_q <= 1'b0;
      end else if (ce) begin
         ack_pend_q <= wr_ctrl & wdat[CAS_CTRL_ACK_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Suppression
   assign rearm = ref_wr & sup_en_q;
   assign blk = sup_en_q & blocked_q;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         blocked_q <= 1'b1;
      end else if (ce) begin
         if (rearm) begin
            blocked_q <= 1'b1;
         end else if (normal_s) begin
            blocked_q <= 1'b0;
         end
      end
   end

   // Onset delay
   assign arm_trig = trig_s & ~mask_q & ~blk;
   assign act = arm_trig & (delay_q == '0 || cnt_q >= delay_q);

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cnt_q <= '0;
      end else if (ce) begin
         if (!arm_trig) begin
            cnt_q <= '0;
         end else if (tick && cnt_q < delay_q) begin
            cnt_q <= cnt_q + DELAY_W'(1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Hold and acknowledge
   assign latching = pol_q == CAS_POL_AUTO || pol_q == CAS_POL_MANUAL;
   assign ack_ok = ack_pend_q & (act | lat_q) &
                   ~(pol_q == CAS_POL_MANUAL && act);
   assign clr = ~act & (~latching | acked_q | ack_ok);

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         lat_q <= 1'b0;
         acked_q <= 1'b0;
      end else if (ce) begin
         if (mask_q || rearm) begin
            lat_q <= 1'b0;
            acked_q <= 1'b0;
         end else begin
            // Held state survives blocking until acknowledged
            lat_q <= act | (lat_q & ~clr);
            acked_q <= clr ? 1'b0 : (acked_q | ack_ok);
         end
      end
   end

   always_comb begin
      if (mask_q) begin
         st = CAS_STATE_OFF;
      end else if (act) begin
         st = acked_q ? CAS_STATE_ACT_ACK : CAS_STATE_ACT_UNACK;
      end else if (lat_q && latching) begin
         st = CAS_STATE_INACT_UNACK;
      end else begin
         st = CAS_STATE_OFF;
      end
   end

   assign out_d = st != CAS_STATE_OFF;
   assign ev[CAS_IRQ_RAISE_BIT] = out_d & ~alarm_out & (pol_q != CAS_POL_TRIGGER_ONLY);
   assign ev[CAS_IRQ_CLEAR_BIT] = ~out_d & alarm_out;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         alarm_state <= CAS_STATE_OFF;
         alarm_out <= 1'b0;
         annunciate <= 1'b0;
      end else if (ce) begin
         alarm_state <= st;
         alarm_out <= out_d;
         annunciate <= out_d & (pol_q != CAS_POL_TRIGGER_ONLY);
      end
   end

   // Interrupts: an event in the clearing cycle still sets its bit
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         irq_stat_q <= '0;
         irq <= 1'b0;
      end else if (ce) begin
         if (wr && wb_adr_i == CAS_OFS_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~wb_dat_i[CAS_IRQ_W-1:0]) | ev;
         end else begin
            irq_stat_q <= irq_stat_q | ev;
         end
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   sequence s_manual_early;
      ce && pol_q == CAS_POL_MANUAL && act && ack_pend_q && !rearm
      ##1 ce && pol_q == CAS_POL_MANUAL && !act && !ack_pend_q && !mask_q && !rearm;
   endsequence

   a_mask_forces_off: assert property (ce && mask_q |=> alarm_state == CAS_STATE_OFF)
      else $error("status not off while masked");
   a_out_tracks_state: assert property (alarm_out == (alarm_state != CAS_STATE_OFF))
      else $error("alarm output disagrees with status");
   a_zero_delay_now: assert property (ce && delay_q == '0 && arm_trig |=> alarm_out)
      else $error("zero delay did not activate at once");
   a_delay_holds_off: assert property (ce && cnt_q < delay_q && !lat_q |=> !alarm_out)
      else $error("alarm active before delay expiry");
   a_drop_clears_timer: assert property (ce && !arm_trig |=> cnt_q == '0)
      else $error("delay timer not reset on drop");
   a_ack_self_clear: assert property (ce && ack_pend_q && !wr_ctrl |=> !ack_pend_q)
      else $error("acknowledge did not return to zero");
   a_manual_early_ack: assert property (s_manual_early |=> alarm_state == CAS_STATE_INACT_UNACK)
      else $error("early acknowledge was not ignored");
   a_manual_ack_ignored: assert property (ce && pol_q == CAS_POL_MANUAL && act && ack_pend_q
                                          && !acked_q && !rearm |=> !acked_q)
      else $error("acknowledge taken while trigger active");
   a_auto_ack_active: assert property (ce && pol_q == CAS_POL_AUTO && act && ack_pend_q
                                       && !rearm |=> acked_q)
      else $error("acknowledge refused while active");
   a_none_clears: assert property (ce && pol_q == CAS_POL_NONE && !act
                                   |=> alarm_state == CAS_STATE_OFF)
      else $error("non-holding alarm stayed on");
   a_trigger_silent: assert property (ce && pol_q == CAS_POL_TRIGGER_ONLY |=> !annunciate)
      else $error("trigger-only alarm annunciated");
   a_rearm_blocks: assert property (ce && rearm |=> blocked_q)
      else $error("reference write did not re-arm blocking");
endmodule

// ===== common/cas_pkg.sv
/*
 Package for the configurable alarm state logic: register map, field
 positions, reset values, status codes and timing constants.
 Assumes a 10 MHz system clock and a 32-bit classic Wishbone slave port.
*/
package cas_pkg;
   // Register byte offsets
   localparam logic [5:0] CAS_OFS_CTRL = 6'h00;
   localparam logic [5:0] CAS_OFS_DELAY = 6'h04;
   localparam logic [5:0] CAS_OFS_REF = 6'h08;
   localparam logic [5:0] CAS_OFS_STATUS = 6'h0C;
   localparam logic [5:0] CAS_OFS_IRQ_STAT = 6'h10;
   localparam logic [5:0] CAS_OFS_IRQ_MASK = 6'h14;
   // Control fields
   localparam int CAS_CTRL_POL_LSB = 0;
   localparam int CAS_CTRL_SUP_BIT = 2;
   localparam int CAS_CTRL_MASK_BIT = 3;
   localparam int CAS_CTRL_ACK_BIT = 4;
   // Status fields
   localparam int CAS_ST_STATE_LSB = 0;
   localparam int CAS_ST_OUT_BIT = 2;
   localparam int CAS_ST_TRIG_BIT = 3;
   localparam int CAS_ST_BLK_BIT = 4;
   localparam int CAS_ST_TIMING_BIT = 5;
   // Interrupt event bits
   localparam int CAS_IRQ_RAISE_BIT = 0;
   localparam int CAS_IRQ_CLEAR_BIT = 1;
   localparam int CAS_IRQ_W = 2;
   // Hold policy codes
   localparam logic [1:0] CAS_POL_NONE = 2'h0;
   localparam logic [1:0] CAS_POL_AUTO = 2'h1;
   localparam logic [1:0] CAS_POL_MANUAL = 2'h2;
   localparam logic [1:0] CAS_POL_TRIGGER_ONLY = 2'h3;
   // Alarm status codes
   localparam logic [1:0] CAS_STATE_OFF = 2'h0;
   localparam logic [1:0] CAS_STATE_ACT_ACK = 2'h1;
   localparam logic [1:0] CAS_STATE_INACT_UNACK = 2'h2;
   localparam logic [1:0] CAS_STATE_ACT_UNACK = 2'h3;
   // Reset values
   localparam logic [1:0] CAS_RST_POL = CAS_POL_NONE;
   localparam logic CAS_RST_SUP = 1'b0;
   localparam logic CAS_RST_MASK = 1'b0;
   localparam logic [31:0] CAS_RST_DELAY = 32'h0000_0000;
   localparam logic [31:0] CAS_RST_REF = 32'h0000_0000;
   localparam logic [CAS_IRQ_W-1:0] CAS_RST_IRQ_MASK = 2'h0;
   // Timing
   localparam int CAS_CLK_PERIOD_NS = 100;
   localparam int CAS_TICK_PERIOD_NS = 100_000_000;
   localparam int CAS_TICK_CYC = CAS_TICK_PERIOD_NS / CAS_CLK_PERIOD_NS;
   localparam int CAS_DELAY_MAX_TENTHS = 99999;
   localparam int CAS_DELAY_W = 17;
endpackage

// ===== rtl/cas_sync3.sv
/*
 Three-flop input synchroniser with agreement filter.
 Assumes an asynchronous level input; output changes once stages two
 and three agree.
*/
`timescale 1ns/1ps
module cas_sync3 (
   // Clocking
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   // Data
   input wire logic d,
   output logic q
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         q <= 1'b0;
      end else if (ce) begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // Only the later stages filter, the first may be metastable
         if (s2_q == s3_q) begin
            q <= s3_q;
         end
      end
   end
endmodule

// ===== rtl/cas_tick.sv
/*
 Tenth-of-a-second tick generator.
 Assumes the system clock; DIV is the number of clocks per tick.
*/
`timescale 1ns/1ps
module cas_tick #(
   parameter int DIV = 1_000_000
) (
   // Clocking
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   // Tick
   output logic tick
);
   logic [31:0] cnt_q;

   if (DIV < 1) begin : g_bad_div
      $error("cas_tick: DIV must be at least one");
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cnt_q <= 32'h0;
         tick <= 1'b0;
      end else if (ce) begin
         if (cnt_q >= 32'(DIV - 1)) begin
            cnt_q <= 32'h0;
            tick <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 32'h1;
            tick <= 1'b0;
         end
      end
   end
endmodule

// ===== verif/cas_src_model.sv
/*
 Far-side model: trigger source and working-condition indicator.
 Assumes the bench commands both levels; outputs move after a rising edge.
*/
`timescale 1ns/1ps
module cas_src_model (
   // Clocking
   input wire logic mclk,
   input wire logic nrst,
   // Commands from the bench
   input wire logic trig_cmd,
   input wire logic normal_cmd,
   // Levels towards the block
   output logic trigger_in,
   output logic value_normal_in
);
   ////////////////////////////////////////////////////////////////////////
   // Value starts outside its working range after every reset
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         value_normal_in <= 1'b0;
      end else begin
         value_normal_in <= normal_cmd;
      end
   end
   // Clean level; may drop before the onset delay runs out
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         trigger_in <= 1'b0;
      end else begin
         trigger_in <= trig_cmd;
      end
   end
endmodule

// ===== verif/tb_cas_alarm.sv
/*
 Self-checking bench for the alarm state logic: policy table, then reset,
 blocking, delay, mask, interrupt and bus cases.
 Assumes the far-side model and a shortened tick divider of 10 clocks.
*/
`timescale 1ns/1ps
`define CHK(g, e) check_val(32'(g), 32'(e))
module tb_cas_alarm
   import cas_pkg::*;
;
   localparam int TDIV = 10;
   localparam int LIMIT = 20000;
   localparam logic [31:0] F_SUP = 32'h1 << CAS_CTRL_SUP_BIT;
   localparam logic [31:0] F_MASK = 32'h1 << CAS_CTRL_MASK_BIT;
   localparam logic [31:0] F_ACK = 32'h1 << CAS_CTRL_ACK_BIT;
   typedef struct packed {logic [1:0] pol; logic [1:0] held; logic ann;} cas_row_t;
   localparam cas_row_t ROWS [4] = '{'{CAS_POL_NONE, CAS_STATE_OFF, 1'b1},
      '{CAS_POL_AUTO, CAS_STATE_INACT_UNACK, 1'b1},
      '{CAS_POL_MANUAL, CAS_STATE_INACT_UNACK, 1'b1},
      '{CAS_POL_TRIGGER_ONLY, CAS_STATE_OFF, 1'b0}};
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [5:0] adr = 6'h00;
   logic [3:0] sel = 4'hF;
   logic [31:0] dat = 32'h0;
   logic trig_cmd = 1'b0;
   logic normal_cmd = 1'b0;
   logic [31:0] dat_o;
   logic ack, trigger_in, value_normal_in, alarm_out, annunciate, irq;
   logic [1:0] alarm_state;
   logic [31:0] rd;
   int n_mismatch = 0;
   int checked = 0;
   int cycles = 0;

   always #50 mclk = ~mclk;

   cas_alarm #(.TICK_DIV(TDIV)) dut (.mclk(mclk), .nrst(nrst), .ce(ce),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .trigger_in(trigger_in),
      .value_normal_in(value_normal_in), .alarm_out(alarm_out),
      .alarm_state(alarm_state), .annunciate(annunciate), .irq(irq));
   cas_src_model src (.mclk(mclk), .nrst(nrst), .trig_cmd(trig_cmd),
      .normal_cmd(normal_cmd), .trigger_in(trigger_in), .value_normal_in(value_normal_in));

   ////////////////////////////////////////////////////////////////////////
   task automatic check_val(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic tally_and_finish();
      $display("mismatches %0d, checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // Ack is waited for, never assumed; a stuck bus runs into the bench timeout
   task automatic wb_cycle(input logic w, input logic [5:0] a, input logic [31:0] d,
                           output logic [31:0] q);
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge mclk);
      end while (ack !== 1'b1);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic wb_wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb_cycle(1'b1, a, d, q);
      wait_cyc(3);
   endtask

   task automatic wb_rd(input logic [5:0] a, output logic [31:0] q);
      wb_cycle(1'b0, a, 32'h0, q);
   endtask

   // Covers sync stages plus registered status
   task automatic set_trig(input logic v);
      @(posedge mclk);
      trig_cmd <= v;
      wait_cyc(12);
   endtask

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      wait_cyc(16);
      nrst <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         wb_wr(CAS_OFS_CTRL, 32'(ROWS[i].pol));
         set_trig(1'b1);
         `CHK(alarm_state, CAS_STATE_ACT_UNACK);
         `CHK(alarm_out, 1'b1);
         `CHK(annunciate, ROWS[i].ann);
         set_trig(1'b0);
         `CHK(alarm_state, ROWS[i].held);
         `CHK(alarm_out, ROWS[i].held != CAS_STATE_OFF);
         wb_wr(CAS_OFS_CTRL, 32'(ROWS[i].pol) | F_ACK);
         `CHK(alarm_state, CAS_STATE_OFF);
      end
      // Second reset in mid-run with non-default settings
      wb_wr(CAS_OFS_CTRL, F_MASK | F_SUP | 32'h2);
      wb_wr(CAS_OFS_DELAY, 32'h5);
      nrst <= 1'b0;
      wait_cyc(16);
      nrst <= 1'b1;
      wb_rd(CAS_OFS_CTRL, rd);
      `CHK(rd, 32'h0);
      wb_rd(CAS_OFS_DELAY, rd);
      `CHK(rd, 32'h0);
      wb_rd(CAS_OFS_STATUS, rd);
      `CHK(rd[1:0], CAS_STATE_OFF);
      // Held alarm survives blocking; reference write re-blocks
      wb_wr(CAS_OFS_CTRL, 32'(CAS_POL_AUTO));
      set_trig(1'b1);
      set_trig(1'b0);
      wb_wr(CAS_OFS_CTRL, 32'(CAS_POL_AUTO) | F_SUP);
      `CHK(alarm_state, CAS_STATE_INACT_UNACK);
      wb_wr(CAS_OFS_REF, 32'h1234);
      `CHK(alarm_state, CAS_STATE_OFF);
      set_trig(1'b1);
      `CHK(alarm_state, CAS_STATE_OFF);
      set_trig(1'b0);
      normal_cmd <= 1'b1;
      set_trig(1'b1);
      `CHK(alarm_state, CAS_STATE_ACT_UNACK);
      wb_wr(CAS_OFS_CTRL, 32'(CAS_POL_AUTO) | F_SUP | F_ACK);
      `CHK(alarm_state, CAS_STATE_ACT_ACK);
      wb_rd(CAS_OFS_CTRL, rd);
      `CHK(rd[CAS_CTRL_ACK_BIT], 1'b0);
      set_trig(1'b0);
      `CHK(alarm_state, CAS_STATE_OFF);
      // Early acknowledge under manual hold is ignored
      wb_wr(CAS_OFS_CTRL, 32'(CAS_POL_MANUAL));
      set_trig(1'b1);
      wb_wr(CAS_OFS_CTRL, 32'(CAS_POL_MANUAL) | F_ACK);
      set_trig(1'b0);
      `CHK(alarm_state, CAS_STATE_INACT_UNACK);
      wb_wr(CAS_OFS_CTRL, 32'(CAS_POL_MANUAL) | F_ACK);
      // Onset delay of three ticks, short pulse then long one
      wb_wr(CAS_OFS_CTRL, 32'(CAS_POL_NONE));
      wb_wr(CAS_OFS_DELAY, 32'h3);
      set_trig(1'b1);
      `CHK(alarm_state, CAS_STATE_OFF);
      set_trig(1'b0);
      set_trig(1'b1);
      `CHK(alarm_state, CAS_STATE_OFF);
      wait_cyc(30);
      `CHK(alarm_state, CAS_STATE_ACT_UNACK);
      set_trig(1'b0);
      wb_wr(CAS_OFS_DELAY, 32'h0001_FFFF);
      wb_rd(CAS_OFS_DELAY, rd);
      `CHK(rd, CAS_DELAY_MAX_TENTHS);
      wb_wr(CAS_OFS_DELAY, 32'h0);
      // Masking an active alarm, then a trigger under mask
      set_trig(1'b1);
      wb_wr(CAS_OFS_CTRL, F_MASK);
      `CHK(alarm_state, CAS_STATE_OFF);
      `CHK(alarm_out, 1'b0);
      wb_wr(CAS_OFS_CTRL, 32'h0);
      wait_cyc(9);
      `CHK(alarm_state, CAS_STATE_ACT_UNACK);
      set_trig(1'b0);
      wb_wr(CAS_OFS_CTRL, F_MASK);
      set_trig(1'b1);
      `CHK(alarm_state, CAS_STATE_OFF);
      wb_wr(CAS_OFS_CTRL, 32'h0);
      wait_cyc(9);
      `CHK(alarm_state, CAS_STATE_ACT_UNACK);
      set_trig(1'b0);
      // Clock enable low freezes status and synchronisers
      set_trig(1'b1);
      ce <= 1'b0;
      set_trig(1'b0);
      `CHK(alarm_state, CAS_STATE_ACT_UNACK);
      ce <= 1'b1;
      wait_cyc(12);
      `CHK(alarm_state, CAS_STATE_OFF);
      // Interrupt: masked, enabled, cleared by writing one
      wb_wr(CAS_OFS_IRQ_STAT, 32'h3);
      set_trig(1'b1);
      `CHK(irq, 1'b0);
      wb_wr(CAS_OFS_IRQ_MASK, 32'h1);
      `CHK(irq, 1'b1);
      wb_rd(CAS_OFS_IRQ_STAT, rd);
      `CHK(rd[CAS_IRQ_RAISE_BIT], 1'b1);
      wb_wr(CAS_OFS_IRQ_STAT, 32'h1);
      `CHK(irq, 1'b0);
      set_trig(1'b0);
      `CHK(irq, 1'b0);
      // Unmapped place reads zero and ignores writes
      wb_wr(6'h20, 32'hFFFF_FFFF);
      wb_rd(6'h20, rd);
      `CHK(rd, 32'h0);
      wb_rd(CAS_OFS_CTRL, rd);
      `CHK(rd, 32'h0);
      tally_and_finish();
   end
endmodule
